// ### hdl/paa_top.v
// Behaviour
// - Eight-deep rolling averages, bus and sense, per channel
// - Averages advance every completed conversion cycle
// - Readable results change only on snapshot commands
// - Averages valid after eight cycles since reset
// - Offset permutation steps through four positions
// - Results carried internally as 17-bit signed
// - Polarity register picks unipolar or bipolar output
// - Power math is always signed
// - Power is sense times bus top 14 bits
// - Unipolar results export 16 unsigned bits
// - Bipolar bus result truncated to 16-bit signed
// - Bipolar sense truncated; power keeps 17 bits
// - Each power product added to channel accumulator
// - Power products 28 bits, accumulators 48 bits
// - Accumulator saturates at its limit
// - Sample counter is 24 bits wide
// - Counter overflow does not clear the counter
// - Bipolar power scaling when any input bipolar
// - Power computed and added right after conversion
// - Overflow flag set on accumulator or counter overflow
// - Flag cleared by plain or broadcast snapshot only
`timescale 1ns/1ps
`include "paa_defines.vh"

module paa_top
(
  input wire CLK,
  input wire ARST_N,
  input wire SAMPLE_VALID,
  input wire [1:0] SAMPLE_CHAN,
  input wire [16:0] SAMPLE_BUS,
  input wire [16:0] SAMPLE_SENSE,
  input wire CYCLE_DONE,
  input wire REG_WR,
  input wire [7:0] REG_ADDR,
  input wire [7:0] REG_WDATA,
  input wire SNAP_REQ,
  input wire [1:0] SNAP_KIND,
  input wire [1:0] RES_CHAN,
  input wire [2:0] RES_SEL,
  output reg [7:0] REG_RDATA,
  output reg [47:0] RES_DATA,
  output reg OVERFLOW,
  output reg AVG_VALID,
  output reg BIPOLAR_POWER,
  output reg [1:0] PERMUTE_POS
);

  reg [7:0] polarity;
  reg [16:0] raw_bus [0:3];
  reg [16:0] raw_sense [0:3];
  reg [30:0] prod;
  reg [1:0] prod_chan;
  reg prod_vld;
  reg [23:0] count;
  reg [3:0] fill;
  reg [15:0] snap_bus [0:3];
  reg [15:0] snap_sense [0:3];
  reg [15:0] snap_bus_avg [0:3];
  reg [15:0] snap_sense_avg [0:3];
  reg [27:0] snap_power [0:3];
  reg [47:0] snap_acc [0:3];
  reg [27:0] last_power [0:3];
  reg [23:0] snap_count;
  reg [47:0] next_res;
  reg next_ovf;
  reg [23:0] next_count;

  wire signed [16:0] mul_sense;
  wire signed [13:0] mul_bus;
  wire signed [30:0] mul_out;
  wire snap_clear;
  wire count_ovf;
  wire any_ovf;
  wire [27:0] power_word;
  wire [3:0] acc_ovf;
  wire [47:0] acc_val [0:3];
  wire [16:0] bus_avg [0:3];
  wire [16:0] sense_avg [0:3];

  // Cut each 17-bit signed value down to a readable 16-bit word
  function [15:0] fmt;
    input [16:0] val;
    input bipolar;
    begin
      if (bipolar)
        fmt = val[16:1];
      else if (val[16])
        fmt = 16'h0000;
      else
        fmt = val[15:0];
    end
  endfunction

  assign mul_sense = SAMPLE_SENSE;
  assign mul_bus = SAMPLE_BUS[16:3];
  assign mul_out = mul_sense * mul_bus;
  assign snap_clear = SNAP_REQ & ((SNAP_KIND == `PAA_SNAP_PLAIN) |
                      (SNAP_KIND == `PAA_SNAP_BCAST));
  assign count_ovf = CYCLE_DONE & (count == `PAA_COUNT_MAX);
  assign power_word = prod[30:3];

  always @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      polarity <= `PAA_POLARITY_RESET;
    else if (REG_WR && REG_ADDR == `PAA_POLARITY_ADDR)
      polarity <= REG_WDATA;
  end

  always @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      REG_RDATA <= 8'h00;
    else if (REG_ADDR == `PAA_POLARITY_ADDR)
      REG_RDATA <= polarity;
    else
      REG_RDATA <= 8'h00;
  end

  // One pipeline stage for the product, a second for the add
  always @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      prod <= 31'h00000000;
      prod_chan <= 2'h0;
    end
    else if (SAMPLE_VALID)
    begin
      prod <= mul_out;
      prod_chan <= SAMPLE_CHAN;
    end
  end

  // Valid kept apart so an idle slot never adds a stale product
  always @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      prod_vld <= 1'b0;
    else
      prod_vld <= SAMPLE_VALID;
  end

  always @*
  begin
    next_count = count;
    if (snap_clear)
      next_count = CYCLE_DONE ? `PAA_COUNT_ONE : 24'h000000;
    else if (CYCLE_DONE && !count_ovf)
      next_count = count + `PAA_COUNT_ONE;
    // Counter holds at its top when full
  end

  always @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      count <= 24'h000000;
    else
      count <= next_count;
  end

  // Fill count saturates so validity never drops again
  always @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      fill <= 4'h0;
      AVG_VALID <= 1'b0;
    end
    else
    begin
      if (CYCLE_DONE && fill != `PAA_AVG_FILL)
        fill <= fill + 4'h1;
      AVG_VALID <= (fill == `PAA_AVG_FILL);
    end
  end

  // One position shared by every input
  always @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      PERMUTE_POS <= 2'h0;
    else if (CYCLE_DONE)
      PERMUTE_POS <= PERMUTE_POS + `PAA_PERM_STEP;
  end

  assign any_ovf = count_ovf | (|acc_ovf);

  always @*
  begin
    next_ovf = OVERFLOW;
    if (snap_clear)
      next_ovf = 1'b0;
    // Set wins over a coincident clear
    if (any_ovf)
      next_ovf = 1'b1;
  end

  always @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      OVERFLOW <= 1'b0;
    else
      OVERFLOW <= next_ovf;
  end

  always @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      BIPOLAR_POWER <= 1'b0;
    else
      BIPOLAR_POWER <= |polarity;
  end

  always @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      snap_count <= 24'h000000;
    else if (SNAP_REQ)
      snap_count <= count;
  end

  genvar ch;
  generate
    for (ch = 0; ch < 4; ch = ch + 1)
    begin : g_chan
      wire hit;
      wire own_prod;
      wire bus_bip;
      wire sense_bip;
      wire [15:0] bus_word;
      wire [15:0] sense_word;
      wire [15:0] bus_avg_word;
      wire [15:0] sense_avg_word;

      assign hit = SAMPLE_VALID && (SAMPLE_CHAN == ch);
      assign own_prod = prod_vld && (prod_chan == ch);
      assign bus_bip = polarity[`PAA_POL_BUS_LSB + ch];
      assign sense_bip = polarity[`PAA_POL_SENSE_LSB + ch];
      assign bus_word = fmt(raw_bus[ch], bus_bip);
      assign sense_word = fmt(raw_sense[ch], sense_bip);
      assign bus_avg_word = fmt(bus_avg[ch], bus_bip);
      assign sense_avg_word = fmt(sense_avg[ch], sense_bip);

      always @(posedge CLK or negedge ARST_N)
      begin
        if (!ARST_N)
        begin
          raw_bus[ch] <= 17'h00000;
          raw_sense[ch] <= 17'h00000;
          last_power[ch] <= 28'h0000000;
        end
        else
        begin
          if (hit)
          begin
            raw_bus[ch] <= SAMPLE_BUS;
            raw_sense[ch] <= SAMPLE_SENSE;
          end
          if (own_prod)
            last_power[ch] <= power_word;
        end
      end

      paa_avg u_bus_avg
      (
        .clk(CLK),
        .arst_n(ARST_N),
        .load(CYCLE_DONE),
        .din(raw_bus[ch]),
        .avg(bus_avg[ch])
      );

      paa_avg u_sense_avg
      (
        .clk(CLK),
        .arst_n(ARST_N),
        .load(CYCLE_DONE),
        .din(raw_sense[ch]),
        .avg(sense_avg[ch])
      );

      paa_acc u_acc
      (
        .clk(CLK),
        .arst_n(ARST_N),
        .clear(snap_clear),
        .add(own_prod),
        .power(power_word),
        .acc(acc_val[ch]),
        .ovf(acc_ovf[ch])
      );

      // Host view frozen between snapshots
      always @(posedge CLK or negedge ARST_N)
      begin
        if (!ARST_N)
        begin
          snap_bus[ch] <= 16'h0000;
          snap_sense[ch] <= 16'h0000;
          snap_bus_avg[ch] <= 16'h0000;
          snap_sense_avg[ch] <= 16'h0000;
          snap_power[ch] <= 28'h0000000;
          snap_acc[ch] <= 48'h000000000000;
        end
        else if (SNAP_REQ)
        begin
          snap_bus[ch] <= bus_word;
          snap_sense[ch] <= sense_word;
          snap_bus_avg[ch] <= bus_avg_word;
          snap_sense_avg[ch] <= sense_avg_word;
          snap_power[ch] <= last_power[ch];
          snap_acc[ch] <= acc_val[ch];
        end
      end
    end
  endgenerate

  always @*
  begin
    next_res = 48'h000000000000;
    case (RES_SEL)
      `PAA_SEL_BUS:
        next_res = {32'h00000000, snap_bus[RES_CHAN]};
      `PAA_SEL_SENSE:
        next_res = {32'h00000000, snap_sense[RES_CHAN]};
      `PAA_SEL_BUS_AVG:
        next_res = {32'h00000000, snap_bus_avg[RES_CHAN]};
      `PAA_SEL_SENSE_AVG:
        next_res = {32'h00000000, snap_sense_avg[RES_CHAN]};
      `PAA_SEL_POWER:
        next_res = {20'h00000, snap_power[RES_CHAN]};
      `PAA_SEL_ACC:
        next_res = snap_acc[RES_CHAN];
      `PAA_SEL_COUNT:
        next_res = {24'h000000, snap_count};
      default:
        next_res = 48'h000000000000;
    endcase
  end

  always @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      RES_DATA <= 48'h000000000000;
    else
      RES_DATA <= next_res;
  end

endmodule // paa_top

// ### hdl/paa_defines.vh
`ifndef PAA_DEFINES_VH
`define PAA_DEFINES_VH

`define PAA_POLARITY_ADDR 8'h1d
`define PAA_POLARITY_RESET 8'h00
`define PAA_POL_SENSE_LSB 0
`define PAA_POL_BUS_LSB 4

`define PAA_SNAP_PLAIN 2'h0
`define PAA_SNAP_BCAST 2'h1
`define PAA_SNAP_KEEP 2'h2

`define PAA_SEL_BUS 3'h0
`define PAA_SEL_SENSE 3'h1
`define PAA_SEL_BUS_AVG 3'h2
`define PAA_SEL_SENSE_AVG 3'h3
`define PAA_SEL_POWER 3'h4
`define PAA_SEL_ACC 3'h5
`define PAA_SEL_COUNT 3'h6

`define PAA_AVG_FILL 4'h8
`define PAA_COUNT_MAX 24'hffffff
`define PAA_COUNT_ONE 24'h000001
`define PAA_PERM_STEP 2'h1
`define PAA_ACC_MAX 48'h7fffffffffff
`define PAA_ACC_MIN 48'h800000000000

`endif

// ### hdl/paa_avg.v
`timescale 1ns/1ps
`include "paa_defines.vh"

module paa_avg
(
  input wire clk,
  input wire arst_n,
  input wire load,
  input wire [16:0] din,
  output wire [16:0] avg
);

  reg [16:0] mem [0:7];
  reg [2:0] idx;
  reg [19:0] sum;
  wire [19:0] din_ext;
  wire [19:0] old_ext;
  integer i;

  assign din_ext = {{3{din[16]}}, din};
  assign old_ext = {{3{mem[idx][16]}}, mem[idx]};
  // Running sum avoids an eight-input adder tree
  assign avg = sum[19:3];

  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      idx <= 3'h0;
      sum <= 20'h00000;
      for (i = 0; i < 8; i = i + 1)
        mem[i] <= 17'h00000;
    end
    else if (load)
    begin
      mem[idx] <= din;
      idx <= idx + 3'h1;
      sum <= sum + din_ext - old_ext;
    end
  end

endmodule // paa_avg

// ### hdl/paa_acc.v
`timescale 1ns/1ps
`include "paa_defines.vh"

module paa_acc
(
  input wire clk,
  input wire arst_n,
  input wire clear,
  input wire add,
  input wire [27:0] power,
  output reg [47:0] acc,
  output reg ovf
);

  wire [48:0] sum;
  wire [47:0] ext;
  wire pos_over;
  wire neg_over;

  assign ext = {{20{power[27]}}, power};
  assign sum = {acc[47], acc} + {ext[47], ext};
  assign pos_over = (sum[48:47] == 2'b01);
  assign neg_over = (sum[48:47] == 2'b10);

  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      acc <= 48'h000000000000;
      ovf <= 1'b0;
    end
    else if (clear)
    begin
      acc <= add ? ext : 48'h000000000000;
      ovf <= 1'b0;
    end
    else if (add)
    begin
      // Clamp instead of wrapping so energy never jumps back
      if (pos_over)
        acc <= `PAA_ACC_MAX;
      else if (neg_over)
        acc <= `PAA_ACC_MIN;
      else
        acc <= sum[47:0];
      ovf <= pos_over | neg_over;
    end
    else
      ovf <= 1'b0;
  end

endmodule // paa_acc

// ### sim/paa_props.sv
`timescale 1ns/1ps
module paa_props
(
  input wire CLK,
  input wire ARST_N,
  input wire CYCLE_DONE,
  input wire REG_WR,
  input wire [7:0] REG_ADDR,
  input wire [7:0] REG_WDATA,
  input wire SNAP_REQ,
  input wire [1:0] SNAP_KIND,
  input wire [1:0] RES_CHAN,
  input wire [2:0] RES_SEL,
  input wire [7:0] REG_RDATA,
  input wire [47:0] RES_DATA,
  input wire OVERFLOW,
  input wire AVG_VALID,
  input wire BIPOLAR_POWER,
  input wire [1:0] PERMUTE_POS
);
  reg [3:0] nc;
  wire wp = REG_WR && REG_ADDR == 8'h1d;
  default clocking dc @(posedge CLK);
  endclocking
  default disable iff (!ARST_N);
  // Stops at eight so it never wraps
  always @(posedge CLK or negedge ARST_N)
    if (!ARST_N)
      nc <= 4'h0;
    else if (CYCLE_DONE && nc != 4'h8)
      nc <= nc + 4'h1;
  // Flag is registered, so it trails the count by one cycle
  a_avg_valid: assert property (
    AVG_VALID == $past(nc == 4'h8)) else $error("avg valid");
  a_perm_step: assert property (
    CYCLE_DONE |=> PERMUTE_POS == $past(PERMUTE_POS) + 2'h1)
    else $error("perm step");
  a_perm_hold: assert property (
    !CYCLE_DONE |=> $stable(PERMUTE_POS)) else $error("perm hold");
  a_pol_read: assert property (
    wp ##1 (!REG_WR && REG_ADDR == 8'h1d) |=>
    REG_RDATA == $past(REG_WDATA, 2)) else $error("pol read");
  a_no_reg: assert property (
    REG_ADDR != 8'h1d |=> REG_RDATA == 8'h00) else $error("unmapped");
  // Two cycles allowed, flag may come from the stored value
  a_bip_flag: assert property (
    wp ##1 !REG_WR |=> BIPOLAR_POWER == |$past(REG_WDATA, 2))
    else $error("bipolar flag");
  a_res_hold: assert property (
    !$past(SNAP_REQ) && $stable(RES_SEL) && $stable(RES_CHAN) |=>
    $stable(RES_DATA)) else $error("result moved");
  a_ovf_hold: assert property (
    OVERFLOW && !(SNAP_REQ && !SNAP_KIND[1]) |=> OVERFLOW)
    else $error("overflow dropped");
  cover property (SNAP_REQ && SNAP_KIND == 2'h2);
  cover property ($rose(AVG_VALID));
  cover property (wp ##2 BIPOLAR_POWER);
endmodule // paa_props

bind paa_top paa_props chk_u (.CLK, .ARST_N, .CYCLE_DONE, .REG_WR,
  .REG_ADDR, .REG_WDATA, .SNAP_REQ, .SNAP_KIND, .RES_CHAN, .RES_SEL,
  .REG_RDATA, .RES_DATA, .OVERFLOW, .AVG_VALID, .BIPOLAR_POWER,
  .PERMUTE_POS);

// ### sim/paa_host.sv
`timescale 1ns/1ps
module paa_host
(
  input wire CLK,
  output reg REG_WR,
  output reg [7:0] REG_ADDR,
  output reg [7:0] REG_WDATA,
  output reg SNAP_REQ,
  output reg [1:0] SNAP_KIND,
  output reg [1:0] RES_CHAN,
  output reg [2:0] RES_SEL,
  output reg [1:0] got
);
  initial
  begin
    {REG_WR, REG_ADDR, REG_WDATA, SNAP_REQ} = 18'h0;
    {SNAP_KIND, RES_CHAN, RES_SEL, got} = 9'h0;
  end
  task wr(input [7:0] a, input [7:0] d);
  begin
    @(posedge CLK);
    REG_WR <= 1'b1;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(posedge CLK);
    REG_WR <= 1'b0;
  end
  endtask
  task snap(input [1:0] k);
  begin
    @(posedge CLK);
    SNAP_REQ <= 1'b1;
    SNAP_KIND <= k;
    @(posedge CLK);
    SNAP_REQ <= 1'b0;
  end
  endtask
  // Kind 1 result word, 2 register; answer flagged a cycle late
  task rd(input [1:0] k, input [7:0] x);
  begin
    @(posedge CLK);
    if (k[1])
      REG_ADDR <= x;
    else
      {RES_CHAN, RES_SEL} <= x[4:0];
    @(posedge CLK);
    got <= k;
    @(posedge CLK);
    got <= 2'h0;
  end
  endtask
endmodule // paa_host

// ### sim/testbench.sv
`timescale 1ns/1ps
module testbench;
  reg CLK, ARST_N, SAMPLE_VALID, CYCLE_DONE;
  reg [1:0] SAMPLE_CHAN;
  reg [16:0] SAMPLE_BUS, SAMPLE_SENSE;
  wire REG_WR, SNAP_REQ, OVERFLOW, AVG_VALID, BIPOLAR_POWER;
  wire [7:0] REG_ADDR, REG_WDATA, REG_RDATA;
  wire [1:0] SNAP_KIND, RES_CHAN, PERMUTE_POS, got;
  wire [2:0] RES_SEL;
  wire [47:0] RES_DATA;
  reg [47:0] q[$];
  reg [47:0] ea[4];
  reg [19:0] sb[4], ss[4];
  reg [16:0] lb[4], ls[4];
  reg [27:0] lp[4];
  reg [63:0] r;
  reg [47:0] o;
  reg [7:0] pol;
  integer bad_count, n_checks, i, j;
  paa_top dut_u (.CLK, .ARST_N, .SAMPLE_VALID, .SAMPLE_CHAN, .SAMPLE_BUS,
    .SAMPLE_SENSE, .CYCLE_DONE, .REG_WR, .REG_ADDR, .REG_WDATA, .SNAP_REQ,
    .SNAP_KIND, .RES_CHAN, .RES_SEL, .REG_RDATA, .RES_DATA, .OVERFLOW,
    .AVG_VALID, .BIPOLAR_POWER, .PERMUTE_POS);
  paa_host host_u (.CLK, .REG_WR, .REG_ADDR, .REG_WDATA, .SNAP_REQ,
    .SNAP_KIND, .RES_CHAN, .RES_SEL, .got);
  initial
  begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  function [47:0] fmt(input [16:0] v, input b);
    fmt = b ? {32'h0, v[16:1]} : (v[16] ? 48'h0 : {32'h0, v[15:0]});
  endfunction
  function [27:0] pw(input [16:0] b, input [16:0] s);
    reg signed [30:0] p;
  begin
    p = $signed(s) * $signed(b[16:3]);
    pw = p[30:3];
  end
  endfunction
  task chk(input [47:0] e, input [47:0] a);
  begin
    n_checks = n_checks + 1;
    if (a !== e)
    begin
      bad_count = bad_count + 1;
      $display("BAD %0t exp %h got %h", $time, e, a);
    end
  end
  endtask
  task results;
  begin
    $display("checks %0d bad %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  end
  endtask
  // One sample per channel, then the cycle end a cycle later
  task conv;
  begin
    for (j = 0; j < 4; j = j + 1)
    begin
      @(posedge CLK);
      r = {$urandom, $urandom};
      lb[j] = r[16:0];
      ls[j] = r[33:17];
      lp[j] = pw(lb[j], ls[j]);
      ea[j] = ea[j] + {{20{lp[j][27]}}, lp[j]};
      sb[j] = sb[j] + {{3{lb[j][16]}}, lb[j]};
      ss[j] = ss[j] + {{3{ls[j][16]}}, ls[j]};
      SAMPLE_VALID <= 1'b1;
      SAMPLE_CHAN <= j[1:0];
      SAMPLE_BUS <= lb[j];
      SAMPLE_SENSE <= ls[j];
    end
    @(posedge CLK);
    SAMPLE_VALID <= 1'b0;
    CYCLE_DONE <= 1'b1;
    @(posedge CLK);
    CYCLE_DONE <= 1'b0;
  end
  endtask
  task ex(input [47:0] e, input [1:0] c, input [2:0] s);
  begin
    q.push_back(e);
    host_u.rd(2'h1, {3'h0, c, s});
  end
  endtask
  task rg(input [7:0] a, input [7:0] e);
  begin
    q.push_back({40'h0, e});
    host_u.rd(2'h2, a);
  end
  endtask
  always @(posedge CLK)
    if (got != 2'h0)
      chk(q.pop_front(), got[1] ? {40'h0, REG_RDATA} : RES_DATA);
  initial
  begin
    i = $urandom(32'h7013);
    {ARST_N, SAMPLE_VALID, CYCLE_DONE, SAMPLE_CHAN} = 5'h0;
    {SAMPLE_BUS, SAMPLE_SENSE} = 34'h0;
    for (i = 0; i < 4; i = i + 1)
      {ea[i], sb[i], ss[i]} = 88'h0;
    bad_count = 0;
    n_checks = 0;
    pol = 8'ha5;
    repeat (5) @(posedge CLK);
    ARST_N <= 1'b1;
    rg(8'h1d, 8'h00);
    host_u.wr(8'h20, 8'hff);
    host_u.wr(8'h1d, pol);
    rg(8'h1d, pol);
    rg(8'h20, 8'h00);
    $display("test registers ended");
    // Averages only read once eight cycles have passed
    repeat (8) conv;
    host_u.snap(2'h2);
    for (i = 0; i < 4; i = i + 1)
    begin
      ex(fmt(lb[i], pol[4 + i]), i[1:0], 3'h0);
      ex(fmt(ls[i], pol[i]), i[1:0], 3'h1);
      ex(fmt(sb[i][19:3], pol[4 + i]), i[1:0], 3'h2);
      ex(fmt(ss[i][19:3], pol[i]), i[1:0], 3'h3);
      ex({20'h0, lp[i]}, i[1:0], 3'h4);
      ex(ea[i], i[1:0], 3'h5);
    end
    ex(48'h8, 2'h0, 3'h6);
    ex(48'h0, 2'h0, 3'h7);
    chk(48'h1, {47'h0, AVG_VALID});
    chk(48'h1, {47'h0, BIPOLAR_POWER});
    $display("test results ended");
    o = ea[0];
    conv;
    ex(o, 2'h0, 3'h5);
    host_u.snap(2'h0);
    ex(ea[0], 2'h0, 3'h5);
    ex(48'h9, 2'h0, 3'h6);
    host_u.snap(2'h1);
    ex(48'h0, 2'h0, 3'h5);
    host_u.snap(2'h3);
    ex(48'h0, 2'h0, 3'h6);
    chk(48'h1, {46'h0, PERMUTE_POS});
    chk(48'h0, {47'h0, OVERFLOW});
    $display("test snapshots ended");
    results;
  end
  initial
  begin
    #20000;
    bad_count = bad_count + 1;
    results;
  end
endmodule // testbench
